// ==== design/req_consts.vh ====
// Purpose: Constants of the standard request responder
// Assumes: Setup bytes arrive low byte first
// Notes:   Codes and field values shared by the design and verif files
`ifndef REQ_CONSTS_VH
`define REQ_CONSTS_VH
`define SETUP_BYTES     4'h8
`define CODE_GET_STATUS 8'h00
`define CODE_CLR_FEAT   8'h01
`define CODE_SET_FEAT   8'h03
`define CODE_SET_ADDR   8'h05
`define CODE_GET_DESC   8'h06
`define CODE_GET_CONF   8'h08
`define CODE_SET_CONF   8'h09
`define CODE_GET_IFACE  8'h0A
`define CODE_SET_IFACE  8'h0B
`define TYPE_OUT_DEV    8'h00
`define TYPE_OUT_IFACE  8'h01
`define TYPE_OUT_EP     8'h02
`define TYPE_IN_DEV     8'h80
`define TYPE_IN_IFACE   8'h81
`define TYPE_IN_EP      8'h82
`define EP0_OUT_IDX     16'h0000
`define EP0_IN_IDX      16'h0080
`define EP1_IDX         16'h0081
`define EP2_IDX         16'h0002
`define DESC_DEVICE     16'h0100
`define DESC_CONFIG     16'h0200
`define DEV_DESC_LEN    9'h012
`define FEAT_WAKEUP     16'h0001
`define FEAT_HALT       16'h0000
`define MAX_ADDR        16'h007F
`define MAX_CONF        8'h01
`define WAKE_BIT        1
`define HALT_BIT        0
`define ST_DEFAULT      2'h0
`define ST_ADDRESSED    2'h1
`define ST_CONFIGURED   2'h2
`define HS_ACK          2'h1
`define HS_NAK          2'h2
`define HS_STALL        2'h3
`define K_NONE          4'h0
`define K_GET_IFACE     4'h1
`define K_GET_CONF      4'h2
`define K_GET_DESC      4'h3
`define K_GET_STATUS    4'h4
`define K_CLR_FEAT      4'h5
`define K_SET_FEAT      4'h6
`define K_SET_IFACE     4'h7
`define K_SET_CONF      4'h8
`define K_SET_ADDR      4'h9
`endif

// ==== design/setup_capture.v ====
// Purpose: Collects the eight bytes of a SETUP data packet
// Assumes: Bytes arrive in offset order after the SETUP token
// Notes:   Byte i sits at bits 8i+7..8i
`timescale 1ns/1ps
`default_nettype none
`include "req_consts.vh"
module setup_capture
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        start,
  input  wire        byte_vld,
  input  wire [7:0]  byte_in,
  output wire [63:0] bytes,
  output reg         done_q
);
  reg [3:0] idx_q;
  reg [7:0] mem_q [0:7];
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_byte
      assign bytes[8*i+7:8*i] = mem_q[i];
      always @(posedge mclk)
      begin
        if (sys_rst)
          mem_q[i] <= 8'h00;
        else if (byte_vld && idx_q == i && idx_q < `SETUP_BYTES)
          mem_q[i] <= byte_in;
      end
    end
  endgenerate
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      idx_q  <= 4'h0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
        idx_q <= 4'h0;
      else if (byte_vld && idx_q < `SETUP_BYTES)
      begin
        idx_q <= idx_q + 4'h1;
        if (idx_q == `SETUP_BYTES - 4'h1)
          done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/std_req_responder.v ====
// Purpose: Answers standard control requests on endpoint 0 in hardware
// Assumes: SIE gives tokens, setup bytes and host ACK as one-cycle pulses
// Notes:   Descriptor bytes are fetched by the SIE using reply_len
`timescale 1ns/1ps
`default_nettype none
`include "req_consts.vh"
module std_req_responder
#(
  parameter IFACES = 5
)
(
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        setup_tok,
  input  wire        rx_vld,
  input  wire [7:0]  rx_byte,
  input  wire        stage_tok,
  input  wire        stage_is_status,
  input  wire        host_ack,
  input  wire        resp_ready,
  input  wire [2:0]  active_interface_count,
  input  wire [4:0]  active_alt_setting,
  input  wire [3:0]  ep_one_interface_map,
  input  wire [3:0]  ep_two_interface_map,
  input  wire [7:0]  desc_len_m1,
  output reg         hs_vld_q,
  output reg  [1:0]  hs_code_q,
  output reg         zlp_send_q,
  output reg  [8:0]  reply_len_q,
  output reg  [15:0] reply_data_q,
  output reg  [3:0]  req_kind_q,
  output reg         firmware_decode_irq,
  output reg  [63:0] setup_bytes_q,
  output reg  [1:0]  dev_state_q,
  output reg  [6:0]  usb_addr_q,
  output reg  [7:0]  config_value_q,
  output reg  [7:0]  device_status_low,
  output reg  [7:0]  ep_zero_status_low,
  output reg  [15:0] endpoint_status_low,
  output reg         ep_zero_halt_flag,
  output reg  [4:0]  alt_q,
  output reg  [2:0]  toggle_reset_q
);
  wire [63:0] cap;
  wire        cap_done;
  setup_capture u_cap
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .start   (setup_tok),
    .byte_vld(rx_vld),
    .byte_in (rx_byte),
    .bytes   (cap),
    .done_q  (cap_done)
  );

  // Field split
  wire [7:0]  rtype = cap[7:0];
  wire [7:0]  rcode = cap[15:8];
  wire [15:0] wval  = cap[31:16];
  wire [15:0] widx  = cap[47:32];
  wire [15:0] wlen  = cap[63:48];
  wire        cfg   = dev_state_q == `ST_CONFIGURED;

  // Endpoint validity per mapping
  wire ep1_ok = cfg && ep_one_interface_map[2:0] <= active_interface_count
                && alt_q[ep_one_interface_map[2:0]] == ep_one_interface_map[3];
  wire ep2_ok = cfg && ep_two_interface_map[2:0] <= active_interface_count
                && alt_q[ep_two_interface_map[2:0]] == ep_two_interface_map[3];
  wire t_ep0  = widx == `EP0_OUT_IDX || widx == `EP0_IN_IDX;
  wire t_ep1  = widx == `EP1_IDX;
  wire t_ep2  = widx == `EP2_IDX;
  wire t_epx  = t_ep0 || t_ep1 || t_ep2;
  wire epx_ok = t_ep0 || (t_ep1 && ep1_ok) || (t_ep2 && ep2_ok);
  wire if_ok  = widx[15:3] == 13'h0000
                && widx[2:0] <= active_interface_count;
  wire alt_ok = wval[15:1] == 15'h0000
                && (!wval[0] || active_alt_setting[widx[2:0]]);
  wire [8:0] desc_sz = (wval == `DESC_DEVICE) ? `DEV_DESC_LEN
                       : {1'b0, desc_len_m1} + 9'h001;

  reg [3:0] kind;
  reg       bad;
  reg       has_data;
  always @*
  begin
    kind     = `K_NONE;
    bad      = 1'b0;
    has_data = 1'b0;
    case (rcode)
      `CODE_GET_IFACE:
        if (rtype == `TYPE_IN_IFACE && wval == 16'h0000 && wlen == 16'h0001
            && widx[15:3] == 13'h0000)
        begin
          kind = `K_GET_IFACE;
          bad  = !cfg || !if_ok;
        end
      `CODE_GET_CONF:
        if (rtype == `TYPE_IN_DEV && wval == 16'h0000 && widx == 16'h0000
            && wlen == 16'h0001)
          kind = `K_GET_CONF;
      `CODE_GET_DESC:
        if (rtype == `TYPE_IN_DEV && widx == 16'h0000
            && (wval == `DESC_DEVICE || wval == `DESC_CONFIG))
          kind = `K_GET_DESC;
      `CODE_GET_STATUS:
        if (wval == 16'h0000 && wlen == 16'h0002)
        begin
          if (rtype == `TYPE_IN_DEV && widx == 16'h0000)
            kind = `K_GET_STATUS;
          else if (rtype == `TYPE_IN_EP && t_epx)
          begin
            kind = `K_GET_STATUS;
            bad  = !epx_ok;
          end
        end
      `CODE_CLR_FEAT, `CODE_SET_FEAT:
        if (wlen == 16'h0000)
        begin
          if (rtype == `TYPE_OUT_DEV && wval == `FEAT_WAKEUP && widx == 16'h0000)
            kind = (rcode == `CODE_CLR_FEAT) ? `K_CLR_FEAT : `K_SET_FEAT;
          else if (rtype == `TYPE_OUT_EP && wval == `FEAT_HALT && t_epx)
          begin
            kind = (rcode == `CODE_CLR_FEAT) ? `K_CLR_FEAT : `K_SET_FEAT;
            bad  = !epx_ok;
          end
        end
      `CODE_SET_IFACE:
        if (rtype == `TYPE_OUT_IFACE && wlen == 16'h0000 && wval[15:3] == 13'h0000
            && widx[15:3] == 13'h0000)
        begin
          kind = `K_SET_IFACE;
          bad  = !cfg || !if_ok || !alt_ok;
        end
      `CODE_SET_CONF:
        if (rtype == `TYPE_OUT_DEV && widx == 16'h0000 && wlen == 16'h0000
            && wval[15:8] == 8'h00)
        begin
          kind = `K_SET_CONF;
          bad  = wval[7:0] > `MAX_CONF;
        end
      `CODE_SET_ADDR:
        if (rtype == `TYPE_OUT_DEV && widx == 16'h0000 && wlen == 16'h0000)
        begin
          kind = `K_SET_ADDR;
          bad  = wval > `MAX_ADDR;
        end
      default:
        kind = `K_NONE;
    endcase
    has_data = kind == `K_GET_IFACE || kind == `K_GET_CONF
               || kind == `K_GET_DESC || kind == `K_GET_STATUS;
  end

  // Reply contents for data stages
  reg [8:0]  rlen;
  reg [15:0] rdat;
  always @*
  begin
    rlen = 9'h000;
    rdat = 16'h0000;
    case (kind)
      `K_GET_IFACE:
      begin
        rlen = 9'h001;
        rdat = {15'h0000, alt_q[widx[2:0]]};
      end
      `K_GET_CONF:
      begin
        rlen = 9'h001;
        rdat = {8'h00, config_value_q};
      end
      `K_GET_DESC:
        rlen = (wlen < {7'h00, desc_sz}) ? wlen[8:0] : desc_sz;
      `K_GET_STATUS:
      begin
        rlen = 9'h002;
        if (rtype == `TYPE_IN_DEV)
          rdat = {8'h00, device_status_low};
        else if (t_ep0)
          rdat = {8'h00, ep_zero_status_low};
        else if (t_ep1)
          rdat = {8'h00, endpoint_status_low[7:0]};
        else
          rdat = {8'h00, endpoint_status_low[15:8]};
      end
      default:
        rlen = 9'h000;
    endcase
  end

  // Request context
  reg active_q;
  reg stall_q;
  reg fw_q;
  reg exempt_q;
  reg data_q;
  reg done_q;
  wire halt_block = ep_zero_halt_flag && !exempt_q && !fw_q;
  wire commit = host_ack && stage_is_status && active_q && !fw_q && !stall_q
                && !halt_block && !done_q && !data_q && resp_ready;
  wire [15:0] cv = setup_bytes_q[31:16];
  wire [15:0] ci = setup_bytes_q[47:32];
  wire        c_dev = setup_bytes_q[7:0] == `TYPE_OUT_DEV;
  wire        c_ep0 = ci == `EP0_OUT_IDX || ci == `EP0_IN_IDX;
  wire        c_ep1 = ci == `EP1_IDX;

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      active_q            <= 1'b0;
      stall_q             <= 1'b0;
      fw_q                <= 1'b0;
      exempt_q            <= 1'b0;
      data_q              <= 1'b0;
      done_q              <= 1'b0;
      req_kind_q          <= `K_NONE;
      setup_bytes_q       <= 64'h0;
      reply_len_q         <= 9'h000;
      reply_data_q        <= 16'h0000;
      firmware_decode_irq <= 1'b0;
    end
    else
    begin
      firmware_decode_irq <= 1'b0;
      if (setup_tok)
      begin
        active_q <= 1'b0;
        stall_q  <= 1'b0;
        done_q   <= 1'b0;
      end
      else if (cap_done)
      begin
        active_q      <= 1'b1;
        setup_bytes_q <= cap;
        req_kind_q    <= kind;
        fw_q          <= kind == `K_NONE;
        firmware_decode_irq <= kind == `K_NONE;
        stall_q       <= bad;
        data_q        <= has_data;
        reply_len_q   <= rlen;
        reply_data_q  <= rdat;
        exempt_q      <= ((kind == `K_GET_STATUS && rtype == `TYPE_IN_EP)
                          || kind == `K_SET_FEAT || kind == `K_CLR_FEAT)
                         && rtype == `TYPE_OUT_EP | rtype == `TYPE_IN_EP
                         && t_ep0;
      end
      else if (stage_tok && stage_is_status)
        data_q <= 1'b0;
      if (commit)
        done_q <= 1'b1;
    end
  end

  // Handshake and null packet generation
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      hs_vld_q   <= 1'b0;
      hs_code_q  <= `HS_NAK;
      zlp_send_q <= 1'b0;
    end
    else
    begin
      hs_vld_q   <= 1'b0;
      zlp_send_q <= 1'b0;
      if (stage_tok && active_q && fw_q)
        zlp_send_q <= !stage_is_status && setup_bytes_q[7]
                      && setup_bytes_q[63:48] == 16'h0000;
      else if (stage_tok)
      begin
        hs_vld_q <= 1'b1;
        if (active_q && (stall_q || halt_block))
          hs_code_q <= `HS_STALL;
        else if (!active_q || !resp_ready)
          hs_code_q <= `HS_NAK;
        else
          hs_code_q <= `HS_ACK;
      end
    end
  end

  // State, address and status bytes
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dev_state_q         <= `ST_DEFAULT;
      usb_addr_q          <= 7'h00;
      config_value_q      <= 8'h00;
      device_status_low   <= 8'h00;
      ep_zero_status_low  <= 8'h00;
      endpoint_status_low <= 16'h0000;
      ep_zero_halt_flag   <= 1'b0;
      toggle_reset_q      <= 3'h0;
    end
    else
    begin
      toggle_reset_q <= 3'h0;
      if (commit)
      begin
        case (req_kind_q)
          `K_CLR_FEAT, `K_SET_FEAT:
          begin
            if (c_dev)
              device_status_low[`WAKE_BIT] <= req_kind_q == `K_SET_FEAT;
            else if (c_ep0)
            begin
              ep_zero_status_low[`HALT_BIT] <= req_kind_q == `K_SET_FEAT;
              ep_zero_halt_flag <= req_kind_q == `K_SET_FEAT;
            end
            else if (c_ep1)
              endpoint_status_low[`HALT_BIT] <= req_kind_q == `K_SET_FEAT;
            else
              endpoint_status_low[8+`HALT_BIT] <= req_kind_q == `K_SET_FEAT;
            if (!c_dev && req_kind_q == `K_CLR_FEAT)
              toggle_reset_q <= {!c_ep0 && !c_ep1, c_ep1, c_ep0};
          end
          `K_SET_CONF:
          begin
            config_value_q <= cv[7:0];
            if (cv[0])
              dev_state_q <= `ST_CONFIGURED;
            else
              dev_state_q <= (usb_addr_q != 7'h00) ? `ST_ADDRESSED : `ST_DEFAULT;
          end
          `K_SET_ADDR:
          begin
            usb_addr_q <= cv[6:0];
            if (dev_state_q != `ST_CONFIGURED)
              dev_state_q <= (cv[6:0] != 7'h00) ? `ST_ADDRESSED : `ST_DEFAULT;
          end
          default:
            dev_state_q <= dev_state_q;
        endcase
      end
    end
  end

  // Current alternate setting per interface
  genvar g;
  generate
    for (g = 0; g < IFACES; g = g + 1)
    begin : g_alt
      always @(posedge mclk)
      begin
        if (sys_rst)
          alt_q[g] <= 1'b0;
        else if (commit && req_kind_q == `K_SET_IFACE && ci[2:0] == g)
          alt_q[g] <= cv[0];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verif/std_req_chk.sv ====
// Purpose: Port checks of the standard request responder
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "req_consts.vh"
module std_req_chk
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        rx_vld,
  input wire logic        stage_tok,
  input wire logic        host_ack,
  input wire logic        resp_ready,
  input wire logic        hs_vld_q,
  input wire logic [1:0]  hs_code_q,
  input wire logic        zlp_send_q,
  input wire logic [3:0]  req_kind_q,
  input wire logic        firmware_decode_irq,
  input wire logic [1:0]  dev_state_q,
  input wire logic [6:0]  usb_addr_q,
  input wire logic [7:0]  config_value_q,
  input wire logic [7:0]  device_status_low,
  input wire logic [7:0]  ep_zero_status_low,
  input wire logic [15:0] endpoint_status_low,
  input wire logic        ep_zero_halt_flag,
  input wire logic [2:0]  toggle_reset_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_hs_cause: assert property ((hs_vld_q || zlp_send_q) |-> $past(stage_tok))
    else $error("handshake without stage token");
  a_zlp_alone: assert property (zlp_send_q |-> !hs_vld_q)
    else $error("null packet with handshake");
  a_nak_unready: assert property (stage_tok && !resp_ready && req_kind_q != `K_NONE
    |=> hs_vld_q && hs_code_q != `HS_ACK)
    else $error("ack while reply not ready");
  a_irq_decode: assert property (firmware_decode_irq |-> req_kind_q == `K_NONE && $past(rx_vld, 2))
    else $error("decode pulse without last byte");
  a_addr_state: assert property (dev_state_q == `ST_ADDRESSED |-> usb_addr_q != 7'h00)
    else $error("addressed with zero address");
  a_conf_state: assert property (dev_state_q == `ST_CONFIGURED |-> config_value_q == `MAX_CONF)
    else $error("configured without value one");
  a_halt_mirror: assert property (ep_zero_halt_flag == ep_zero_status_low[`HALT_BIT])
    else $error("halt flag differs from status bit");
  a_stat_commit: assert property (!$past(sys_rst) && ($changed(device_status_low)
    || $changed(ep_zero_status_low) || $changed(endpoint_status_low)) |-> $past(host_ack))
    else $error("status changed without host ack");
  a_toggle_commit: assert property (|toggle_reset_q |-> $past(host_ack))
    else $error("toggle reset without host ack");
endmodule
bind std_req_responder std_req_chk chk_u (.mclk, .sys_rst, .rx_vld, .stage_tok, .host_ack,
  .resp_ready, .hs_vld_q, .hs_code_q, .zlp_send_q, .req_kind_q, .firmware_decode_irq,
  .dev_state_q, .usb_addr_q, .config_value_q, .device_status_low, .ep_zero_status_low,
  .endpoint_status_low, .ep_zero_halt_flag, .toggle_reset_q);
`default_nettype wire

// ==== verif/host_model.sv ====
// Purpose: Host side of endpoint 0 control transfers
// Assumes: Signals change at the falling clock edge
// Notes:   Sends whole setup packets only
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input wire logic   mclk,
  output logic       setup_tok,
  output logic       rx_vld,
  output logic [7:0] rx_byte,
  output logic       stage_tok,
  output logic       stage_is_status,
  output logic       host_ack
);
  initial {setup_tok, rx_vld, rx_byte, stage_tok, stage_is_status, host_ack} = '0;
  // Token, then eight bytes in offset order
  task automatic setup(input logic [63:0] pkt);
    @(negedge mclk);
    setup_tok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      setup_tok = 1'b0;
      rx_vld = 1'b1;
      rx_byte = pkt[8*i +: 8];
    end
    @(negedge mclk);
    rx_vld = 1'b0;
    rx_byte = ~rx_byte;
  endtask
  task automatic stage(input logic st);
    @(negedge mclk);
    stage_is_status = st;
    stage_tok = 1'b1;
    @(negedge mclk);
    stage_tok = 1'b0;
  endtask
  task automatic ack();
    @(negedge mclk);
    host_ack = 1'b1;
    @(negedge mclk);
    host_ack = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/std_req_responder_bench.sv ====
// Purpose: Self-checking bench of the standard request responder
// Assumes: Host model drives the setup and stage traffic
// Notes:   Handshakes are checked from a queue of expected codes
`timescale 1ns/1ps
`default_nettype none
`include "req_consts.vh"
module std_req_responder_bench;
  logic        mclk, sys_rst, setup_tok, rx_vld, stage_tok, stage_is_status, host_ack;
  logic        resp_ready, hs_vld_q, zlp_send_q, firmware_decode_irq, ep_zero_halt_flag;
  logic [1:0]  hs_code_q, dev_state_q;
  logic [2:0]  active_interface_count, toggle_reset_q, tog_seen;
  logic [3:0]  ep_one_interface_map, ep_two_interface_map, req_kind_q;
  logic [4:0]  active_alt_setting, alt_q;
  logic [6:0]  usb_addr_q;
  logic [7:0]  rx_byte, desc_len_m1, config_value_q, device_status_low, ep_zero_status_low;
  logic [8:0]  reply_len_q, wl;
  logic [15:0] reply_data_q, endpoint_status_low;
  logic [63:0] setup_bytes_q, pkt;
  logic [2:0]  exp_q[$];
  int          num_errors, tests_run, irq_cnt, cycles;
  localparam logic [2:0] e_ack = {1'b0, `HS_ACK}, e_nak = {1'b0, `HS_NAK};
  localparam logic [2:0] e_stall = {1'b0, `HS_STALL}, e_zlp = 3'h4, e_none = 3'h0;
  localparam logic [63:0] get_conf = {16'h0001, 32'h0, 16'h0880};
  localparam logic [63:0] stat_ep1 = {16'h0002, 16'h0081, 16'h0, 16'h0082};
  std_req_responder dut_u (.mclk, .sys_rst, .setup_tok, .rx_vld, .rx_byte, .stage_tok,
    .stage_is_status, .host_ack, .resp_ready, .active_interface_count, .active_alt_setting,
    .ep_one_interface_map, .ep_two_interface_map, .desc_len_m1, .hs_vld_q, .hs_code_q,
    .zlp_send_q, .reply_len_q, .reply_data_q, .req_kind_q, .firmware_decode_irq,
    .setup_bytes_q, .dev_state_q, .usb_addr_q, .config_value_q, .device_status_low,
    .ep_zero_status_low, .endpoint_status_low, .ep_zero_halt_flag, .alt_q, .toggle_reset_q);
  host_model host_u (.mclk, .setup_tok, .rx_vld, .rx_byte, .stage_tok, .stage_is_status,
    .host_ack);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [63:0] mk(input logic [7:0] t, c, input logic [15:0] v, i, l);
    return {l, i, v, c, t};
  endfunction
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_hs(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Send the setup, note the expected answer, run one stage, ack accepted status stages
  task automatic req(input logic [63:0] p, input logic st, input logic [2:0] e);
    host_u.setup(p);
    if (e != e_none)
      exp_q.push_back(e);
    host_u.stage(st);
    if (st && e == e_ack)
      host_u.ack();
    repeat (2) @(negedge mclk);
  endtask
  task automatic stop_test();
    $display("Counts: comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(negedge mclk)
  begin
    if (firmware_decode_irq === 1'b1)
      irq_cnt++;
    if (!sys_rst && toggle_reset_q !== 3'h0)
      tog_seen = tog_seen | toggle_reset_q;
    if (!sys_rst && (hs_vld_q === 1'b1 || zlp_send_q === 1'b1))
      chk_hs({zlp_send_q, hs_vld_q ? hs_code_q : 2'h0},
             exp_q.size() ? exp_q.pop_front() : 3'h0);
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    resp_ready = 1'b1;
    tog_seen = 3'h0;
    active_interface_count = 3'h1;
    active_alt_setting = 5'h02;
    ep_one_interface_map = 4'h1;
    ep_two_interface_map = 4'h0;
    void'($urandom(74831));
    desc_len_m1 = 8'($urandom());
    wl = 9'($urandom());
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    req(stat_ep1, 1'b0, e_stall);
    req(mk(8'h81, 8'h0A, 16'h0, 16'h0, 16'h1), 1'b0, e_stall);
    req(mk(8'h80, 8'h06, `DESC_CONFIG, 16'h0, {7'h0, wl}), 1'b0, e_ack);
    chk_val(reply_len_q, (wl < desc_len_m1 + 9'h1) ? wl : desc_len_m1 + 9'h1);
    req(mk(8'h80, 8'h06, `DESC_DEVICE, 16'h0, 16'h40), 1'b0, e_ack);
    chk_val(reply_len_q, `DEV_DESC_LEN);
    $display("test descriptors done");
    pkt = mk(8'hC0, 8'h33, 16'h1234, 16'h5678, 16'h0);
    req(pkt, 1'b0, e_zlp);
    chk_val(setup_bytes_q, pkt);
    req(mk(8'h40, 8'h33, 16'h0, 16'h0, 16'h0), 1'b1, e_none);
    req(mk(8'hC0, 8'h33, 16'h0, 16'h0, 16'h8), 1'b0, e_none);
    chk_val(irq_cnt, 3);
    $display("test firmware done");
    req(mk(8'h00, 8'h05, 16'h5, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val({dev_state_q, usb_addr_q}, {`ST_ADDRESSED, 7'h05});
    req(mk(8'h00, 8'h09, 16'h2, 16'h0, 16'h0), 1'b1, e_stall);
    req(mk(8'h00, 8'h09, 16'h1, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val({ep_zero_halt_flag, dev_state_q}, {1'b0, `ST_CONFIGURED});
    chk_val(config_value_q, `MAX_CONF);
    $display("test states done");
    req(stat_ep1, 1'b0, e_ack);
    req(mk(8'h81, 8'h0A, 16'h0, 16'h2, 16'h1), 1'b0, e_stall);
    req(mk(8'h01, 8'h0B, 16'h1, 16'h1, 16'h0), 1'b1, e_ack);
    chk_val(alt_q, 5'h02);
    chk_val(req_kind_q, `K_SET_IFACE);
    req(mk(8'h01, 8'h0B, 16'h1, 16'h2, 16'h0), 1'b1, e_stall);
    req(stat_ep1, 1'b0, e_stall);
    $display("test interfaces done");
    req(mk(8'h02, 8'h03, 16'h0, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val(ep_zero_halt_flag, 1'b1);
    req(get_conf, 1'b0, e_stall);
    req(mk(8'h82, 8'h00, 16'h0, 16'h0, 16'h2), 1'b0, e_ack);
    chk_val(reply_data_q, 64'h1);
    req(mk(8'h02, 8'h01, 16'h0, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val(ep_zero_halt_flag, 1'b0);
    chk_val(tog_seen, 3'h1);
    ep_one_interface_map = 4'h9;
    req(mk(8'h02, 8'h03, 16'h0, 16'h81, 16'h0), 1'b1, e_ack);
    chk_val(endpoint_status_low, 16'h0001);
    req(mk(8'h02, 8'h01, 16'h0, 16'h81, 16'h0), 1'b1, e_ack);
    chk_val({tog_seen, endpoint_status_low}, {3'h3, 16'h0000});
    req(mk(8'h00, 8'h03, 16'h1, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val(device_status_low[`WAKE_BIT], 1'b1);
    req(mk(8'h00, 8'h01, 16'h1, 16'h0, 16'h0), 1'b1, e_ack);
    chk_val(device_status_low[`WAKE_BIT], 1'b0);
    $display("test features done");
    resp_ready = 1'b0;
    req(get_conf, 1'b0, e_nak);
    resp_ready = 1'b1;
    exp_q.push_back(e_ack);
    host_u.stage(1'b0);
    repeat (2) @(negedge mclk);
    chk_val(reply_data_q, 64'h1);
    chk_val(64'(exp_q.size()), 64'h0);
    $display("test ready done");
    stop_test();
  end
endmodule
`default_nettype wire
